// *** rtl/flag_conditional_branch_unit.sv ***
// module: conditional branch on overflow and interrupt-enable flags
`timescale 1ns/1ps
`default_nettype none
module flag_conditional_branch_unit
  import flag_branch_pkg::*;
(
  input  wire logic                  CLOCK,
  input  wire logic                  RST_N,
  input  wire logic                  CLK_EN,
  input  wire logic                  INSTR_VALID,
  input  wire branch_req_type        INSTR,
  input  wire status_flags_type      FLAGS,
  output logic                       INSTR_READY,
  output logic                       BRANCH_TAKEN,
  output logic [PC_WIDTH-1:0]        PROGRAM_COUNTER
);

  // --------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------
  branch_state_type    state_reg;
  branch_state_type    state_next;
  logic [PC_WIDTH-1:0] pc_reg;
  logic [PC_WIDTH-1:0] pc_next;
  logic [PC_WIDTH-1:0] target_reg;
  logic                taken_reg;

  wire logic                cond_met;
  wire logic                accept;
  wire logic [PC_WIDTH-1:0] offset_ext;
  wire logic [PC_WIDTH-1:0] pc_seq;
  wire logic [PC_WIDTH-1:0] pc_target;

  assign cond_met =
      (INSTR.op == BR_OVERFLOW_SET && FLAGS.overflow)
    | (INSTR.op == BR_OVERFLOW_CLR && !FLAGS.overflow)
    | (INSTR.op == BR_IRQ_ENABLED  && FLAGS.irq_enable)
    | (INSTR.op == BR_IRQ_DISABLED && !FLAGS.irq_enable);

  // --------------------------------------------------------------------
  // per-branch condition checks
  // --------------------------------------------------------------------
  // one issue sequence per branch kind; the flag test is fused on with ##0
  sequence ovf_set_issue;
    accept && INSTR.op == BR_OVERFLOW_SET;
  endsequence

  sequence ovf_clr_issue;
    accept && INSTR.op == BR_OVERFLOW_CLR;
  endsequence

  sequence irq_en_issue;
    accept && INSTR.op == BR_IRQ_ENABLED;
  endsequence

  sequence irq_dis_issue;
    accept && INSTR.op == BR_IRQ_DISABLED;
  endsequence

  AST_VS_TAKE: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    ovf_set_issue ##0 FLAGS.overflow |=> state_reg == ST_TAKEN)
    else $error("overflow-set branch not taken with overflow set");

  AST_VC_TAKE: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    ovf_clr_issue ##0 !FLAGS.overflow |=> state_reg == ST_TAKEN)
    else $error("overflow-clear branch not taken with overflow clear");

  AST_VC_COND: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    ovf_clr_issue ##0 FLAGS.overflow
      |=> state_reg == ST_EXEC && pc_reg == $past(pc_reg) + PC_STEP)
    else $error("overflow-clear branch taken with overflow set");

  AST_IE_TAKE: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    irq_en_issue ##0 FLAGS.irq_enable |=> state_reg == ST_TAKEN)
    else $error("irq-enabled branch not taken with irq enabled");

  AST_IE_COND: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    irq_en_issue ##0 !FLAGS.irq_enable
      |=> state_reg == ST_EXEC && pc_reg == $past(pc_reg) + PC_STEP)
    else $error("irq-enabled branch taken with irq disabled");

  AST_ID_TAKE: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    irq_dis_issue ##0 !FLAGS.irq_enable |=> state_reg == ST_TAKEN)
    else $error("irq-disabled branch not taken with irq disabled");

  // an empty selector still consumes one cycle and steps the pc
  AST_NONE_STEP: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (accept && INSTR.op == BR_NONE)
      |=> state_reg == ST_EXEC && pc_reg == $past(pc_reg) + PC_STEP)
    else $error("empty selector did not step the pc");

  // sign extension keeps backward branches reachable
  assign offset_ext = {{(PC_WIDTH-OFFSET_WIDTH){INSTR.offset[OFFSET_WIDTH-1]}},
                       INSTR.offset};
  assign pc_seq     = pc_reg + PC_STEP;
  assign pc_target  = pc_seq + offset_ext;
  assign accept     = CLK_EN && INSTR_VALID && (state_reg == ST_EXEC);
  assign INSTR_READY = (state_reg == ST_EXEC);

  // --------------------------------------------------------------------
  // sequencing
  // --------------------------------------------------------------------
  // taken branch holds the second cycle; the pc lands at its end.
  // flags are inputs only, so no flag is ever altered here.
  always_comb begin
    state_next = state_reg;
    pc_next    = pc_reg;
    case (state_reg)
      ST_EXEC: begin
        if (accept && cond_met) begin
          state_next = ST_TAKEN;
        end else if (accept) begin
          pc_next = pc_seq;
        end
      end
      ST_TAKEN: begin
        state_next = ST_EXEC;
        pc_next    = target_reg;
      end
      default: begin
        state_next = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg  <= ST_EXEC;
      pc_reg     <= PC_RESET;
      target_reg <= PC_RESET;
      taken_reg  <= 1'b0;
    end else if (CLK_EN) begin
      state_reg <= state_next;
      pc_reg    <= pc_next;
      taken_reg <= (state_reg == ST_TAKEN);
      if (accept) begin
        target_reg <= pc_target;
      end
    end
  end

  assign PROGRAM_COUNTER = pc_reg;
  assign BRANCH_TAKEN    = taken_reg;

  // --------------------------------------------------------------------
  // stall and indication checks
  // --------------------------------------------------------------------
  // the stall lasts one enabled cycle; offers made during it are ignored
  AST_STALL_LAND: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (CLK_EN && !INSTR_READY) |=> INSTR_READY && pc_reg == $past(target_reg))
    else $error("stall cycle did not land the branch target");

  AST_TAKEN_PULSE: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (CLK_EN && state_reg != ST_TAKEN) |=> !BRANCH_TAKEN)
    else $error("taken indication without a taken branch");

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  sequence taken_issue;
    accept && cond_met;
  endsequence

  property taken_two_cycles;
    @(posedge CLOCK) disable iff (!RST_N)
    taken_issue ##1 CLK_EN[*1] |-> (state_reg == ST_TAKEN) && !INSTR_READY;
  endproperty

  AST_TAKEN_STALL: assert property (taken_two_cycles)
    else $error("taken branch did not hold a second cycle");

  AST_UNTAKEN_ONE: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (accept && !cond_met) |=> (pc_reg == $past(pc_reg) + PC_STEP)
                              && INSTR_READY)
    else $error("untaken branch did not advance pc by one");

  AST_TARGET: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (accept && cond_met) ##1 CLK_EN |=>
      (pc_reg == $past(pc_reg, 2) + PC_STEP + $past(offset_ext, 2)))
    else $error("taken branch target wrong");

  AST_COND_IRQ_OFF: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (accept && INSTR.op == BR_IRQ_DISABLED && FLAGS.irq_enable)
      |=> state_reg == ST_EXEC)
    else $error("irq-disabled branch taken with irq enabled");

  AST_SIGN_EXT: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    $signed(offset_ext) == PC_WIDTH'($signed(INSTR.offset)))
    else $error("offset not sign extended");

  AST_FREEZE: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    !CLK_EN |=> $stable(pc_reg) && $stable(state_reg))
    else $error("state moved while clock enable low");

  AST_VS_COND: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (accept && INSTR.op == BR_OVERFLOW_SET && !FLAGS.overflow)
      |=> state_reg == ST_EXEC)
    else $error("overflow-set branch taken with overflow clear");

  AST_TAKEN_FLAG: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (state_reg == ST_TAKEN && CLK_EN) |=> BRANCH_TAKEN)
    else $error("taken indication missing");

endmodule
`default_nettype wire

// *** rtl/flag_branch_pkg.sv ***
// package: shared constants and types for the flag conditional branch unit
`default_nettype none
package flag_branch_pkg;
  localparam int PC_WIDTH     = 16;
  localparam int OFFSET_WIDTH = 7;
  localparam logic [PC_WIDTH-1:0] PC_RESET = 16'h0000;
  localparam logic [PC_WIDTH-1:0] PC_STEP  = 16'h0001;
  localparam int CYCLES_UNTAKEN = 1;
  localparam int CYCLES_TAKEN   = 2;

  // branch selector encoding
  typedef enum logic [2:0] {
    BR_NONE          = 3'h0,
    BR_OVERFLOW_SET  = 3'h1,
    BR_OVERFLOW_CLR  = 3'h2,
    BR_IRQ_ENABLED   = 3'h3,
    BR_IRQ_DISABLED  = 3'h4
  } branch_op_type;

  // execute-stage states, gray along idle -> taken
  typedef enum logic [0:0] {
    ST_EXEC  = 1'b0,
    ST_TAKEN = 1'b1
  } branch_state_type;

  typedef struct packed {
    branch_op_type                  op;
    logic signed [OFFSET_WIDTH-1:0] offset;
  } branch_req_type;

  typedef struct packed {
    logic overflow;
    logic irq_enable;
  } status_flags_type;
endpackage
`default_nettype wire

// *** verification/flag_branch_tb.sv ***
// testbench: directed branch scenarios for the flag conditional branch unit
`timescale 1ns/1ps
`default_nettype none
module testbench
  import flag_branch_pkg::*;
;
  logic                  clock = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  clk_en = 1'b1;
  logic                  instr_valid = 1'b0;
  branch_req_type        instr = '0;
  status_flags_type      flags = '0;
  wire logic             ready;
  wire logic             taken;
  wire logic [PC_WIDTH-1:0] pc;
  logic [PC_WIDTH-1:0]   model_pc;
  int                    bad_count = 0;
  int                    n_compared = 0;
  always #20 clock = ~clock;
  flag_conditional_branch_unit i_dut (.CLOCK(clock), .RST_N(rst_n),
    .CLK_EN(clk_en), .INSTR_VALID(instr_valid), .INSTR(instr),
    .FLAGS(flags), .INSTR_READY(ready), .BRANCH_TAKEN(taken),
    .PROGRAM_COUNTER(pc));
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input string what, input logic [PC_WIDTH-1:0] seen,
                       input logic [PC_WIDTH-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // flags flip right after accept: they must have been sampled at accept
  task automatic exec(input branch_op_type op, input logic [6:0] off,
                      input logic ovf, input logic ie);
    logic hit;
    logic [PC_WIDTH-1:0] tgt;
    hit = (op == BR_OVERFLOW_SET && ovf) || (op == BR_OVERFLOW_CLR && !ovf)
       || (op == BR_IRQ_ENABLED && ie) || (op == BR_IRQ_DISABLED && !ie);
    tgt = model_pc + PC_STEP + (hit ? {{9{off[6]}}, off} : 16'h0000);
    @(posedge clock);
    instr_valid <= 1'b1;
    instr <= '{op, off};
    flags <= '{ovf, ie};
    @(posedge clock);
    instr_valid <= 1'b0;
    flags <= '{!ovf, !ie};
    #1;
    if (hit) begin
      check("stall", 16'(ready), 16'h0000);
      @(posedge clock);
      #1;
    end
    check("pc", pc, tgt);
    check("ready", 16'(ready), 16'h0001);
    check("taken", 16'(taken), 16'(hit));
    @(posedge clock);
    #1;
    check("taken end", 16'(taken), 16'h0000);
    check("pc hold", pc, tgt);
    model_pc = tgt;
  endtask
  task automatic test_flags();
    for (int f = 0; f < 2; f++) begin
      exec(BR_OVERFLOW_SET, 7'h05, f[0], 1'b0);
      exec(BR_OVERFLOW_CLR, 7'h09, f[0], 1'b1);
      exec(BR_IRQ_ENABLED, 7'h11, 1'b1, f[0]);
      exec(BR_IRQ_DISABLED, 7'h21, 1'b0, f[0]);
    end
  endtask
  task automatic test_offset();
    exec(BR_OVERFLOW_SET, 7'h40, 1'b1, 1'b0);
    exec(BR_OVERFLOW_CLR, 7'h3F, 1'b0, 1'b0);
    exec(BR_IRQ_ENABLED, 7'h7F, 1'b0, 1'b1);
    exec(BR_NONE, 7'h10, 1'b1, 1'b1);
  endtask
  // reset in the stall cycle must drop the pending branch
  task automatic test_reset();
    @(posedge clock);
    instr_valid <= 1'b1;
    instr <= '{BR_OVERFLOW_SET, 7'h10};
    flags <= '{1'b1, 1'b0};
    @(posedge clock);
    instr_valid <= 1'b0;
    rst_n <= 1'b0;
    #1;
    check("mid reset pc", pc, PC_RESET);
    check("mid reset ready", 16'(ready), 16'h0001);
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    model_pc = PC_RESET;
    @(posedge clock);
    #1;
    check("after reset taken", 16'(taken), 16'h0000);
    check("after reset pc", pc, PC_RESET);
  endtask
  // a low enable must hold off even a pending taken branch
  task automatic test_freeze();
    @(posedge clock);
    clk_en <= 1'b0;
    instr_valid <= 1'b1;
    instr <= '{BR_OVERFLOW_SET, 7'h10};
    flags <= '{1'b1, 1'b1};
    repeat (3) @(posedge clock);
    clk_en <= 1'b1;
    instr_valid <= 1'b0;
    #1;
    check("frozen pc", pc, model_pc);
    @(posedge clock);
    instr_valid <= 1'b1;
    @(posedge clock);
    instr_valid <= 1'b0;
    clk_en <= 1'b0;
    repeat (3) @(posedge clock);
    clk_en <= 1'b1;
    #1;
    check("frozen stall pc", pc, model_pc);
    check("frozen stall", 16'(ready), 16'h0000);
    model_pc = model_pc + PC_STEP + 16'h0010;
    @(posedge clock);
    #1;
    check("late pc", pc, model_pc);
    check("late taken", 16'(taken), 16'h0001);
  endtask
  initial begin
    // registers are unknown until the first edge under reset
    repeat (2) @(posedge clock);
    #1;
    check("reset pc", pc, PC_RESET);
    check("reset ready", 16'(ready), 16'h0001);
    check("reset taken", 16'(taken), 16'h0000);
    repeat (18) @(posedge clock);
    rst_n <= 1'b1;
    model_pc = PC_RESET;
    test_flags();
    test_offset();
    test_reset();
    test_freeze();
    finish_test();
  end
  // the scenarios need about 80 cycles; 500 cycles leaves ample margin
  initial begin
    #20000;
    bad_count++;
    finish_test();
  end
endmodule
`default_nettype wire
